/* core/branch_bit_flag_exec.sv */
// executor for flag branches, io bit ops, shifts and status flag ops
`timescale 1ns/1ns
module branch_bit_flag_exec
  import exec_pkg::*;
#(
  parameter int PC_WIDTH = PC_WIDTH_DEFAULT
) (
  input  wire logic                     CLOCK,
  input  wire logic                     RST,
  input  wire logic                     CMD_VALID,
  input  wire exec_cmd_t                CMD,
  output logic                          CMD_READY,
  input  wire logic [DATA_WIDTH-1:0]    IO_RDATA,
  output logic [IO_ADDR_WIDTH-1:0]      IO_ADDR,
  output logic                          IO_RE,
  output logic [DATA_WIDTH-1:0]         IO_WDATA,
  output logic                          IO_WE,
  output logic [DATA_WIDTH-1:0]         RESULT,
  output logic                          RESULT_WE,
  output logic                          DONE,
  output logic [PC_WIDTH-1:0]           PC,
  output logic [7:0]                    FLAGS
);

  exec_state_t               state_reg;
  exec_state_t               state_next;
  exec_cmd_t                 cmd_reg;
  exec_cmd_t                 cmd_next;
  logic [PC_WIDTH-1:0]       pc_reg;
  logic [PC_WIDTH-1:0]       pc_next;
  logic [7:0]                flag_reg;
  logic [7:0]                flag_next;
  logic [DATA_WIDTH-1:0]     result_reg;
  logic [DATA_WIDTH-1:0]     result_next;
  logic                      result_we_reg;
  logic                      result_we_next;
  logic                      done_reg;
  logic                      done_next;
  logic [IO_ADDR_WIDTH-1:0]  io_addr_reg;
  logic [IO_ADDR_WIDTH-1:0]  io_addr_next;
  logic                      io_re_reg;
  logic                      io_re_next;
  logic [DATA_WIDTH-1:0]     io_wdata_reg;
  logic [DATA_WIDTH-1:0]     io_wdata_next;
  logic                      io_we_reg;
  logic                      io_we_next;

  logic                      accept;
  logic                      is_branch;
  logic                      taken;
  logic [2:0]                flag_idx;
  logic                      flag_val;
  logic [PC_WIDTH-1:0]       pc_seq;
  logic [PC_WIDTH-1:0]       pc_target;
  logic [DATA_WIDTH-1:0]     shift_res;
  logic                      shift_c;
  logic                      is_shift;
  logic                      flag_set;

  assign accept    = CMD_VALID && (state_reg == ST_IDLE);
  assign CMD_READY = (state_reg == ST_IDLE);
  assign pc_seq    = pc_reg + PC_WIDTH'(1);
  // offset sign-extended before the add so backward jumps wrap correctly
  assign pc_target = pc_reg + PC_WIDTH'(1)
                   + {{(PC_WIDTH-OFFSET_WIDTH){cmd_reg.offset[OFFSET_WIDTH-1]}},
                      cmd_reg.offset};                                        // [RULE17]

  // branch decode: which flag, and whether one or zero makes it jump
  always_comb begin
    is_branch = 1'b1;
    flag_idx  = FLAG_C;
    flag_set  = 1'b1;
    unique case (CMD.op)
      OP_BRANCH_FLAG_SET:         begin flag_idx = CMD.sel; flag_set = 1'b1; end // [RULE1]
      OP_BRANCH_FLAG_CLEAR:       begin flag_idx = CMD.sel; flag_set = 1'b0; end // [RULE1]
      OP_BRANCH_EQUAL:            begin flag_idx = FLAG_Z;  flag_set = 1'b1; end // [RULE2]
      OP_BRANCH_NOT_EQUAL:        begin flag_idx = FLAG_Z;  flag_set = 1'b0; end // [RULE2]
      OP_BRANCH_CARRY_SET,
      OP_BRANCH_LOWER:            begin flag_idx = FLAG_C;  flag_set = 1'b1; end // [RULE3]
      OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_HIGHER:      begin flag_idx = FLAG_C;  flag_set = 1'b0; end // [RULE3]
      OP_BRANCH_MINUS:            begin flag_idx = FLAG_N;  flag_set = 1'b1; end // [RULE4]
      OP_BRANCH_PLUS:             begin flag_idx = FLAG_N;  flag_set = 1'b0; end // [RULE4]
      OP_BRANCH_GE_SIGNED:        begin flag_idx = FLAG_S;  flag_set = 1'b0; end // [RULE5]
      OP_BRANCH_LT_SIGNED:        begin flag_idx = FLAG_S;  flag_set = 1'b1; end // [RULE5]
      OP_BRANCH_HALF_CARRY_SET:   begin flag_idx = FLAG_H;  flag_set = 1'b1; end // [RULE6]
      OP_BRANCH_HALF_CARRY_CLEAR: begin flag_idx = FLAG_H;  flag_set = 1'b0; end // [RULE6]
      OP_BRANCH_TRANSFER_SET:     begin flag_idx = FLAG_T;  flag_set = 1'b1; end // [RULE7]
      OP_BRANCH_TRANSFER_CLEAR:   begin flag_idx = FLAG_T;  flag_set = 1'b0; end // [RULE7]
      OP_BRANCH_OVERFLOW_SET:     begin flag_idx = FLAG_V;  flag_set = 1'b1; end // [RULE8]
      OP_BRANCH_OVERFLOW_CLEAR:   begin flag_idx = FLAG_V;  flag_set = 1'b0; end // [RULE8]
      OP_BRANCH_IRQ_ENABLED:      begin flag_idx = FLAG_I;  flag_set = 1'b1; end // [RULE9]
      OP_BRANCH_IRQ_DISABLED:     begin flag_idx = FLAG_I;  flag_set = 1'b0; end // [RULE9]
      default:                    is_branch = 1'b0;
    endcase
  end

  // signed branches look at n xor v directly, not the stored s bit,
  // since other units may leave s stale
  always_comb begin
    if (CMD.op == OP_BRANCH_GE_SIGNED || CMD.op == OP_BRANCH_LT_SIGNED) begin
      flag_val = flag_reg[FLAG_N] ^ flag_reg[FLAG_V];                       // [RULE5]
    end else begin
      flag_val = flag_reg[flag_idx];
    end
    taken = is_branch && (flag_val == flag_set);
  end

  // flag ops are decoded in the main process, one flag bit per op
  // shift unit, shared by all five shift forms
  always_comb begin
    is_shift  = 1'b1;
    shift_res = CMD.operand;
    shift_c   = 1'b0;
    unique case (CMD.op)
      OP_LOGICAL_SHIFT_LEFT:  begin shift_res = {CMD.operand[6:0], 1'b0};          // [RULE11]
                                    shift_c   = CMD.operand[7]; end
      OP_LOGICAL_SHIFT_RIGHT: begin shift_res = {1'b0, CMD.operand[7:1]};          // [RULE11]
                                    shift_c   = CMD.operand[0]; end
      OP_ROTATE_LEFT_CARRY:   begin shift_res = {CMD.operand[6:0], flag_reg[FLAG_C]}; // [RULE11]
                                    shift_c   = CMD.operand[7]; end
      OP_ROTATE_RIGHT_CARRY:  begin shift_res = {flag_reg[FLAG_C], CMD.operand[7:1]}; // [RULE11]
                                    shift_c   = CMD.operand[0]; end
      OP_ARITH_SHIFT_RIGHT:   begin shift_res = {CMD.operand[7], CMD.operand[7:1]};   // [RULE12]
                                    shift_c   = CMD.operand[0]; end
      default:                is_shift = 1'b0;
    endcase
  end

  // main next-state logic
  always_comb begin
    state_next     = state_reg;
    cmd_next       = cmd_reg;
    pc_next        = pc_reg;
    flag_next      = flag_reg;
    result_next    = result_reg;
    result_we_next = 1'b0;
    done_next      = 1'b0;
    io_addr_next   = io_addr_reg;
    io_re_next     = 1'b0;
    io_wdata_next  = io_wdata_reg;
    io_we_next     = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          cmd_next = CMD;
          if (taken) begin
            state_next = ST_BRANCH_TAKEN;                                   // [RULE17]
          end else if (CMD.op == OP_IO_BIT_SET || CMD.op == OP_IO_BIT_CLEAR) begin
            state_next   = ST_IO_MODIFY;                                    // [RULE10]
            io_addr_next = CMD.io_addr;
            io_re_next   = 1'b1;
          end else begin
            // one-cycle forms: not-taken branches fall through
            pc_next   = pc_seq;                                             // [RULE17]
            done_next = 1'b1;
            if (is_shift) begin
              result_next       = shift_res;
              result_we_next    = 1'b1;
              flag_next[FLAG_C] = shift_c;                                  // [RULE11]
              flag_next[FLAG_N] = shift_res[7];                             // [RULE12]
              flag_next[FLAG_Z] = (shift_res == 8'h00);                     // [RULE12]
              flag_next[FLAG_V] = shift_res[7] ^ shift_c;                   // [RULE12]
            end
            unique case (CMD.op)
              OP_FLAG_SET_INDEXED:       flag_next[CMD.sel] = 1'b1;         // [RULE13]
              OP_FLAG_CLEAR_INDEXED:     flag_next[CMD.sel] = 1'b0;         // [RULE13]
              OP_CARRY_SET_OP:           flag_next[FLAG_C]  = 1'b1;         // [RULE13]
              OP_CARRY_CLEAR_OP:         flag_next[FLAG_C]  = 1'b0;         // [RULE13]
              OP_NEGATIVE_SET_OP:        flag_next[FLAG_N]  = 1'b1;         // [RULE13]
              OP_NEGATIVE_CLEAR_OP:      flag_next[FLAG_N]  = 1'b0;         // [RULE13]
              OP_ZERO_SET_OP:            flag_next[FLAG_Z]  = 1'b1;         // [RULE13]
              OP_ZERO_CLEAR_OP:          flag_next[FLAG_Z]  = 1'b0;         // [RULE13]
              OP_SIGNED_SET_OP:          flag_next[FLAG_S]  = 1'b1;         // [RULE13]
              OP_SIGNED_CLEAR_OP:        flag_next[FLAG_S]  = 1'b0;         // [RULE13]
              OP_OVERFLOW_SET_OP:        flag_next[FLAG_V]  = 1'b1;         // [RULE13]
              OP_OVERFLOW_CLEAR_OP:      flag_next[FLAG_V]  = 1'b0;         // [RULE13]
              OP_TRANSFER_FLAG_SET_OP:   flag_next[FLAG_T]  = 1'b1;         // [RULE13]
              OP_TRANSFER_FLAG_CLEAR_OP: flag_next[FLAG_T]  = 1'b0;         // [RULE13]
              OP_HALF_CARRY_SET_OP:      flag_next[FLAG_H]  = 1'b1;
              OP_HALF_CARRY_CLEAR_OP:    flag_next[FLAG_H]  = 1'b0;
              OP_GLOBAL_IRQ_ENABLE:      flag_next[FLAG_I]  = 1'b1;         // [RULE14]
              OP_GLOBAL_IRQ_DISABLE:     flag_next[FLAG_I]  = 1'b0;         // [RULE14]
              OP_BIT_TO_TRANSFER_FLAG:   flag_next[FLAG_T]  = CMD.operand[CMD.sel]; // [RULE15]
              OP_TRANSFER_FLAG_TO_BIT: begin
                result_next           = CMD.operand;                        // [RULE16]
                result_next[CMD.sel]  = flag_reg[FLAG_T];                   // [RULE16]
                result_we_next        = 1'b1;
              end
              default: begin end
            endcase
          end
        end
      end
      ST_BRANCH_TAKEN: begin
        // second cycle of a taken branch; flags are never written here
        pc_next    = pc_target;                                             // [RULE1]
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
      ST_IO_MODIFY: begin
        // read-modify-write: io data must be valid while the read strobe is up
        io_wdata_next          = IO_RDATA;
        io_wdata_next[cmd_reg.sel] = (cmd_reg.op == OP_IO_BIT_SET);         // [RULE10]
        io_we_next             = 1'b1;
        pc_next                = pc_seq;
        done_next              = 1'b1;
        state_next             = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_reg     <= ST_IDLE;
      cmd_reg       <= '0;
      pc_reg        <= '0;
      flag_reg      <= FLAGS_RESET;
      result_reg    <= '0;
      result_we_reg <= 1'b0;
      done_reg      <= 1'b0;
      io_addr_reg   <= '0;
      io_re_reg     <= 1'b0;
      io_wdata_reg  <= '0;
      io_we_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cmd_reg       <= cmd_next;
      pc_reg        <= pc_next;
      flag_reg      <= flag_next;
      result_reg    <= result_next;
      result_we_reg <= result_we_next;
      done_reg      <= done_next;
      io_addr_reg   <= io_addr_next;
      io_re_reg     <= io_re_next;
      io_wdata_reg  <= io_wdata_next;
      io_we_reg     <= io_we_next;
    end
  end

  assign PC        = pc_reg;
  assign FLAGS     = flag_reg;
  assign RESULT    = result_reg;
  assign RESULT_WE = result_we_reg;
  assign DONE      = done_reg;
  assign IO_ADDR   = io_addr_reg;
  assign IO_RE     = io_re_reg;
  assign IO_WDATA  = io_wdata_reg;
  assign IO_WE     = io_we_reg;

endmodule

/* core/exec_pkg.sv */
// constants, types and behaviour notes for the branch, bit and flag executor
// Notes on behaviour
// RULE1: the generic flag branches test the flag picked by the select field and jump to pc+k+1 when it is one (set form) or zero (clear form).
// RULE2: the equal and not-equal branches jump to pc+k+1 on zero flag one or zero, else fall through, leaving all flags alone.
// RULE3: carry-set and lower jump on carry one, carry-clear and same-or-higher jump on carry zero, with no flag altered.
// RULE4: the minus branch jumps on negative one and the plus branch on negative zero, flags untouched.
// RULE5: the signed greater-or-equal branch jumps when negative xor overflow is zero, the signed less-than branch when it is one.
// RULE6: the half-carry branches jump on half-carry one (set form) or zero (clear form).
// RULE7: the transfer-bit branches jump on the t flag one (set form) or zero (clear form).
// RULE8: the overflow branches jump on the overflow flag one (set form) or zero (clear form).
// RULE9: the interrupt-state branches jump on the global interrupt enable being one or zero.
// RULE10: io bit set and clear force bit b of io register p to one or zero in two cycles, no flag touched.
// RULE11: logical shifts insert zero, rotates insert the old carry and load carry from the bit shifted out, in one cycle.
// RULE12: the arithmetic right shift keeps the sign bit, updates zero, carry, negative and overflow, in one cycle.
// RULE13: the flag instructions set or clear exactly one chosen flag, named or picked by index, in one cycle.
// RULE14: the global interrupt enable and disable instructions set or clear the interrupt flag in one cycle.
// RULE15: the bit-store instruction copies bit b of the source operand into the t flag in one cycle, nothing else.
// RULE16: the bit-load instruction writes the t flag into bit b of the destination in one cycle, flags unchanged.
// RULE17: the offset k is signed two's complement; a branch takes one cycle when not taken and two when taken.
package exec_pkg;
  localparam int   DATA_WIDTH       = 8;
  localparam int   OFFSET_WIDTH     = 7;
  localparam int   IO_ADDR_WIDTH    = 5;
  localparam int   PC_WIDTH_DEFAULT = 16;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [2:0] FLAG_C     = 3'h0;
  localparam logic [2:0] FLAG_Z     = 3'h1;
  localparam logic [2:0] FLAG_N     = 3'h2;
  localparam logic [2:0] FLAG_V     = 3'h3;
  localparam logic [2:0] FLAG_S     = 3'h4;
  localparam logic [2:0] FLAG_H     = 3'h5;
  localparam logic [2:0] FLAG_T     = 3'h6;
  localparam logic [2:0] FLAG_I     = 3'h7;

  typedef enum logic [5:0] {
    OP_NOP,
    OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER,
    OP_BRANCH_MINUS, OP_BRANCH_PLUS,
    OP_BRANCH_GE_SIGNED, OP_BRANCH_LT_SIGNED,
    OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR,
    OP_BRANCH_TRANSFER_SET, OP_BRANCH_TRANSFER_CLEAR,
    OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED,
    OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT,
    OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT,
    OP_FLAG_SET_INDEXED, OP_FLAG_CLEAR_INDEXED,
    OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT,
    OP_CARRY_SET_OP, OP_CARRY_CLEAR_OP,
    OP_NEGATIVE_SET_OP, OP_NEGATIVE_CLEAR_OP,
    OP_ZERO_SET_OP, OP_ZERO_CLEAR_OP,
    OP_GLOBAL_IRQ_ENABLE, OP_GLOBAL_IRQ_DISABLE,
    OP_SIGNED_SET_OP, OP_SIGNED_CLEAR_OP,
    OP_OVERFLOW_SET_OP, OP_OVERFLOW_CLEAR_OP,
    OP_TRANSFER_FLAG_SET_OP, OP_TRANSFER_FLAG_CLEAR_OP,
    OP_HALF_CARRY_SET_OP, OP_HALF_CARRY_CLEAR_OP
  } exec_op_t;

  typedef struct packed {
    exec_op_t                  op;
    logic [2:0]                sel;
    logic [OFFSET_WIDTH-1:0]   offset;
    logic [DATA_WIDTH-1:0]     operand;
    logic [IO_ADDR_WIDTH-1:0]  io_addr;
  } exec_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BRANCH_TAKEN,
    ST_IO_MODIFY
  } exec_state_t;
endpackage

/* testbench/branch_bit_flag_exec_monitor.sv */
// port-level assertions for the branch, bit and flag executor
`timescale 1ns/1ns
module branch_bit_flag_exec_monitor
  import exec_pkg::*;
#(
  parameter int PC_WIDTH = PC_WIDTH_DEFAULT
) (
  input wire logic                  CLOCK,
  input wire logic                  RST,
  input wire logic                  CMD_VALID,
  input wire exec_cmd_t             CMD,
  input wire logic                  CMD_READY,
  input wire logic [DATA_WIDTH-1:0] IO_RDATA,
  input wire logic [4:0]            IO_ADDR,
  input wire logic                  IO_RE,
  input wire logic [DATA_WIDTH-1:0] IO_WDATA,
  input wire logic                  IO_WE,
  input wire logic [DATA_WIDTH-1:0] RESULT,
  input wire logic                  RESULT_WE,
  input wire logic                  DONE,
  input wire logic [PC_WIDTH-1:0]   PC,
  input wire logic [7:0]            FLAGS
);
  logic accept;
  assign accept = CMD_VALID && CMD_READY;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  taken_branch_a: assert property (accept && CMD.op == OP_BRANCH_EQUAL && FLAGS[FLAG_Z] |=>
    !DONE && !CMD_READY ##1 DONE
    && PC == $past(PC, 2) + PC_WIDTH'(1) + PC_WIDTH'($signed($past(CMD.offset, 2))))
    else $error("taken branch target or timing wrong");
  not_taken_a: assert property (accept && CMD.op == OP_BRANCH_NOT_EQUAL && FLAGS[FLAG_Z] |=>
    DONE && PC == $past(PC) + PC_WIDTH'(1)) else $error("untaken branch not sequential");
  branch_flags_a: assert property (accept && CMD.op >= OP_BRANCH_FLAG_SET
    && CMD.op <= OP_BRANCH_IRQ_DISABLED |=> $stable(FLAGS)) else $error("branch changed flags");
  signed_branch_a: assert property (accept && CMD.op == OP_BRANCH_LT_SIGNED |=>
    DONE == !($past(FLAGS[FLAG_N]) ^ $past(FLAGS[FLAG_V]))) else $error("signed branch wrong");
  io_read_a: assert property (accept && (CMD.op == OP_IO_BIT_SET || CMD.op == OP_IO_BIT_CLEAR)
    |=> IO_RE && !IO_WE && !CMD_READY && IO_ADDR == $past(CMD.io_addr))
    else $error("io read phase wrong");
  io_set_a: assert property (accept && CMD.op == OP_IO_BIT_SET |=> ##1 IO_WE && DONE
    && IO_WDATA == ($past(IO_RDATA) | (8'h01 << $past(CMD.sel, 2))) && $stable(FLAGS))
    else $error("io bit set wrong");
  shift_left_a: assert property (accept && CMD.op == OP_LOGICAL_SHIFT_LEFT |=> RESULT_WE
    && DONE && RESULT == {$past(CMD.operand[6:0]), 1'b0}
    && FLAGS[FLAG_C] == $past(CMD.operand[7])) else $error("shift left wrong");
  rotate_right_a: assert property (accept && CMD.op == OP_ROTATE_RIGHT_CARRY |=>
    RESULT == {$past(FLAGS[FLAG_C]), $past(CMD.operand[7:1])}
    && FLAGS[FLAG_C] == $past(CMD.operand[0])) else $error("rotate right wrong");
  flag_index_a: assert property (accept && CMD.op == OP_FLAG_CLEAR_INDEXED |=> DONE
    && FLAGS == ($past(FLAGS) & ~(8'h01 << $past(CMD.sel)))) else $error("indexed clear wrong");
  bit_store_a: assert property (accept && CMD.op == OP_BIT_TO_TRANSFER_FLAG |=>
    FLAGS[FLAG_T] == $past(CMD.operand[CMD.sel]) && ((FLAGS ^ $past(FLAGS)) & 8'hBF) == 8'h00)
    else $error("bit store wrong");
endmodule

bind branch_bit_flag_exec branch_bit_flag_exec_monitor #(.PC_WIDTH(PC_WIDTH)) monitor (
  .CLOCK(CLOCK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY),
  .IO_RDATA(IO_RDATA), .IO_ADDR(IO_ADDR), .IO_RE(IO_RE), .IO_WDATA(IO_WDATA), .IO_WE(IO_WE),
  .RESULT(RESULT), .RESULT_WE(RESULT_WE), .DONE(DONE), .PC(PC), .FLAGS(FLAGS));

/* testbench/branch_bit_flag_exec_bench.sv */
// self-checking bench for the branch, bit and flag executor
`timescale 1ns/1ns
module branch_bit_flag_exec_bench;
  import exec_pkg::*;
  localparam logic [2:0] br_flag [10] = '{3'h0, FLAG_Z, FLAG_C, FLAG_C, FLAG_N, 3'h0, FLAG_H,
                                           FLAG_T, FLAG_V, FLAG_I};
  localparam logic [2:0] op_flag [8] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V,
                                          FLAG_T, FLAG_H};
  logic                     CLOCK = 1'b0;
  logic                     RST = 1'b1;
  logic                     CMD_VALID = 1'b0;
  exec_cmd_t                CMD = '0;
  logic [7:0]               io_value = 8'h3C;
  logic [7:0]               IO_RDATA, IO_WDATA, RESULT, FLAGS, exp_flags, res, opnd;
  logic                     CMD_READY, IO_RE, IO_WE, RESULT_WE, DONE, c, tk;
  logic [IO_ADDR_WIDTH-1:0] IO_ADDR;
  logic [15:0]              PC, exp_pc;
  logic [7:0]               vals [3] = '{8'h81, 8'h80, 8'h01};
  exec_op_t                 op;
  int                       miscompares = 0;
  int                       samples_checked = 0;
  int                       i, j, p;
  // released read bus shows inverted data so stale values cannot pass
  assign IO_RDATA = IO_RE ? io_value : ~io_value;

  branch_bit_flag_exec uut (.CLOCK(CLOCK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CMD_READY(CMD_READY), .IO_RDATA(IO_RDATA), .IO_ADDR(IO_ADDR), .IO_RE(IO_RE),
    .IO_WDATA(IO_WDATA), .IO_WE(IO_WE), .RESULT(RESULT), .RESULT_WE(RESULT_WE),
    .DONE(DONE), .PC(PC), .FLAGS(FLAGS));

  initial begin
    forever #50 CLOCK = ~CLOCK;
  end

  task check(input logic [15:0] seen, input logic [15:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask

  task complete_run;
    $display("compares=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task do_reset;
    @(posedge CLOCK);
    #5 RST = 1'b1;
    repeat (3) @(posedge CLOCK);
    #5 RST = 1'b0;
    exp_pc = 16'h0000;
    exp_flags = 8'h00;
    check(PC, exp_pc);
    check({FLAGS, 7'h00, CMD_READY}, 16'h0001);
  endtask

  // one command, held until its accept edge; pc and flags compared at retire
  task run(input exec_op_t cop, input logic [2:0] sel, input logic [6:0] k,
           input logic [7:0] d, input int cycles);
    int n;
    @(posedge CLOCK);
    #5;
    CMD = '{cop, sel, k, d, {sel, 2'b01}};
    CMD_VALID = 1'b1;
    @(posedge CLOCK);
    #5;
    CMD_VALID = 1'b0;
    n = 1;
    while (DONE !== 1'b1 && n < 4) begin
      @(posedge CLOCK);
      #5;
      n++;
    end
    check(16'(n), 16'(cycles));
    if (cop <= OP_BRANCH_IRQ_DISABLED && cycles == 2) exp_pc += {{9{k[6]}}, k};
    exp_pc += 16'h0001;
    check(PC, exp_pc);
    check(16'(FLAGS), 16'(exp_flags));
  endtask

  task set_flags(input logic [7:0] pat);
    for (int b = 0; b < 8; b++) begin
      exp_flags[b] = pat[b];
      run(pat[b] ? OP_FLAG_SET_INDEXED : OP_FLAG_CLEAR_INDEXED, 3'(b), 7'h00, 8'h00, 1);
    end
  endtask

  initial begin
    #1000000;
    miscompares++;
    complete_run;
  end

  initial begin
    do_reset;
    set_flags(8'h5A);
    for (i = 0; i < 16; i++) begin
      exp_flags[op_flag[i / 2]] = !i[0];
      run(exec_op_t'(int'(OP_CARRY_SET_OP) + i), 3'h0, 7'h00, 8'h00, 1);
    end
    run(OP_NOP, 3'h0, 7'h00, 8'h00, 1);
    $display("flag ops finished");
    foreach (vals[p]) begin
      set_flags(p == 0 ? 8'h00 : p == 1 ? 8'hFF : 8'h09);
      for (i = 0; i < 20; i++) begin
        op = exec_op_t'(int'(OP_BRANCH_FLAG_SET) + i);
        j = i / 2;
        tk = (j == 0) ? exp_flags[3'(i + p)] : (j == 5) ? exp_flags[FLAG_N] ^ exp_flags[FLAG_V]
                      : exp_flags[br_flag[j]];
        tk = tk ^ i[0] ^ (j == 3 || j == 5);
        run(op, 3'(i + p), i[0] ? 7'h40 : 7'h3F, 8'h00, tk ? 2 : 1);
      end
    end
    $display("branches finished");
    set_flags(8'h11);
    for (i = 0; i < 15; i++) begin
      op = exec_op_t'(int'(OP_LOGICAL_SHIFT_LEFT) + i / 3);
      opnd = vals[i % 3];
      case (op)
        OP_LOGICAL_SHIFT_LEFT:  {c, res} = {opnd, 1'b0};
        OP_LOGICAL_SHIFT_RIGHT: {res, c} = {1'b0, opnd};
        OP_ROTATE_LEFT_CARRY:   {c, res} = {opnd, exp_flags[FLAG_C]};
        OP_ROTATE_RIGHT_CARRY:  {res, c} = {exp_flags[FLAG_C], opnd};
        default:                {res, c} = {opnd[7], opnd};
      endcase
      exp_flags[3:0] = {res[7] ^ c, res[7], res == 8'h00, c};
      run(op, 3'h0, 7'h00, opnd, 1);
      check(16'({RESULT_WE, RESULT}), 16'({1'b1, res}));
    end
    $display("shifts finished");
    for (i = 0; i < 8; i++) begin
      res = 8'h5A;
      exp_flags[FLAG_T] = res[i];
      run(OP_BIT_TO_TRANSFER_FLAG, 3'(i), 7'h00, 8'h5A, 1);
      res = 8'hA5;
      res[i] = exp_flags[FLAG_T];
      run(OP_TRANSFER_FLAG_TO_BIT, 3'(i), 7'h00, 8'hA5, 1);
      check(16'(RESULT), 16'(res));
    end
    $display("bit transfer finished");
    for (i = 0; i < 16; i++) begin
      io_value = 8'(8'h3C + i);
      res = io_value;
      res[i[2:0]] = !i[3];
      run(i < 8 ? OP_IO_BIT_SET : OP_IO_BIT_CLEAR, 3'(i), 7'h00, 8'h00, 2);
      check(16'({IO_WE, IO_WDATA}), 16'({1'b1, res}));
      check(16'(IO_ADDR), 16'({3'(i), 2'b01}));
    end
    $display("io bit ops finished");
    do_reset;
    run(OP_BRANCH_IRQ_DISABLED, 3'h0, 7'h7F, 8'h00, 2);
    $display("second reset finished");
    complete_run;
  end
endmodule
